// ===== core/clksel_map.svh
// Purpose: Register map, field positions, reset values and counts.
// Assumes: Byte-wide register port, one register per address.
// Notes: Definitions only.
`ifndef CLKSEL_MAP_SVH
`define CLKSEL_MAP_SVH

`define ADDR_HOLDOVER_CTRL 8'h20
`define ADDR_MODE_CTRL 8'h21
`define ADDR_HOLDOFF_COUNT 8'h22
`define ADDR_HOLDOFF_DIV 8'h23

`define BIT_EXT_INT 0
`define BIT_HOLDOVER_CTRL 1
`define BIT_INT_SEL 0
`define BIT_MODE_LO 2
`define BIT_MODE_HI 3
`define BIT_REVERTIVE_ENABLE 4
`define BIT_DIV_LO 6
`define BIT_DIV_HI 7

`define RST_EXT_INT 1'h0
`define RST_HOLDOVER_CTRL 1'h0
`define RST_INT_SEL 1'h0
`define RST_MODE 2'h0
`define RST_REVERTIVE_ENABLE 1'h0
`define RST_HOLDOFF_COUNT 8'h80
`define RST_HOLDOFF_DIV 2'h2

`define DIV_CODE_15 2'h0
`define DIV_CODE_16 2'h1
`define PRESCALE_LAST_15 17'h07fff
`define PRESCALE_LAST_16 17'h0ffff
`define PRESCALE_LAST_17 17'h1ffff
`define PRESCALE_ONE 17'h00001
`define PRESCALE_ZERO 17'h00000
`define COUNT_ONE 8'h01
`define COUNT_ZERO 8'h00

`endif

// ===== core/clksel_pkg.sv
// Purpose: Types shared by the clock input selection logic.
// Assumes: Constants come from clksel_map.svh.
// Notes: Enumerations only.
package clksel_pkg;

	typedef enum logic [1:0] {
		MODE_MANUAL,
		MODE_AUTO,
		MODE_SHORT_HOLDOVER,
		MODE_AUTO_HOLDOVER
	} selection_mode_t;

	typedef enum logic {
		ST_TRACK,
		ST_HOLDOFF
	} sel_state_t;

endpackage : clksel_pkg

// ===== core/holdoff_if.sv
// Purpose: Carries hold-off counter control and status between modules.
// Assumes: One clock, MCLK.
// Notes: ctrl is the selection logic, cnt the counter.
`timescale 1ns/1ps
`default_nettype none

interface holdoff_if;
	logic enable;
	logic vcxo_tick;
	logic [7:0] setting;
	logic [1:0] divider;
	logic expire;
	logic [7:0] count;

	modport ctrl (output enable, output vcxo_tick, output setting,
		output divider, input expire, input count);
	modport cnt (input enable, input vcxo_tick, input setting,
		input divider, output expire, output count);
endinterface : holdoff_if

`default_nettype wire

// ===== core/holdoff_counter.sv
// Purpose: Short-term holdover hold-off counter with VCXO prescaler.
// Assumes: vcxo_tick pulses once per VCXO period, synchronous to MCLK.
// Notes: Held at the setting whenever enable is low.
`timescale 1ns/1ps
`default_nettype none
`include "clksel_map.svh"

module holdoff_counter
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Counter link
	holdoff_if.cnt hif
);

	logic [16:0] prescale;
	logic [16:0] next_prescale;
	logic [7:0] count;
	logic [7:0] next_count;
	logic expire;
	logic next_expire;
	logic [16:0] last;

	always_comb
	begin
		case (hif.divider)
			`DIV_CODE_15: last = `PRESCALE_LAST_15;
			`DIV_CODE_16: last = `PRESCALE_LAST_16;
			default: last = `PRESCALE_LAST_17;
		endcase
	end

	always_comb
	begin
		next_prescale = prescale;
		next_count = count;
		next_expire = 1'b0;
		if (!hif.enable)
		begin
			next_prescale = `PRESCALE_ZERO;
			next_count = hif.setting;
		end
		else if (hif.vcxo_tick)
		begin
			// One count per 2^15, 2^16 or 2^17 VCXO pulses.
			if (prescale >= last)
			begin
				next_prescale = `PRESCALE_ZERO;
				// Reaching zero fires and reloads at once.
				if (count <= `COUNT_ONE)
				begin
					next_expire = 1'b1;
					next_count = hif.setting;
				end
				else
				begin
					next_count = count - `COUNT_ONE;
				end
			end
			else
			begin
				next_prescale = prescale + `PRESCALE_ONE;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			prescale <= `PRESCALE_ZERO;
			count <= `RST_HOLDOFF_COUNT;
			expire <= 1'b0;
		end
		else
		begin
			prescale <= next_prescale;
			count <= next_count;
			expire <= next_expire;
		end
	end

	assign hif.expire = expire;
	assign hif.count = count;

endmodule : holdoff_counter

`default_nettype wire

// ===== core/clock_input_selection_control.sv
// Purpose: Chooses which of two redundant inputs feeds the first-stage PLL.
// Assumes: All inputs synchronous to MCLK; registers written by REG_WR.
// Notes: Priority is the primary designation; in the automatic modes the primary input is taken back by revertive reselection or on loss of the other input.
`timescale 1ns/1ps
`default_nettype none
`include "clksel_map.svh"

module clock_input_selection_control
	import clksel_pkg::*;
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	output logic [7:0] REG_RDATA,
	// Input status
	input wire logic EXT_SEL,
	input wire logic LOS0,
	input wire logic LOS1,
	input wire logic REVAL0,
	input wire logic REVAL1,
	input wire logic VCXO_TICK,
	// Selection outputs
	output logic REF_SEL,
	output logic HOLDOFF_ACTIVE,
	output logic FAILOVER
);

	logic ext_int;
	logic holdover_mode_control;
	logic revertive_enable;
	logic [1:0] selection_mode;
	logic int_sel;
	logic [7:0] holdoff_count;
	logic [1:0] holdoff_ref_divider;
	logic [7:0] rdata;
	logic next_ext_int;
	logic next_holdover_mode_control;
	logic next_revertive_enable;
	logic [1:0] next_selection_mode;
	logic next_int_sel;
	logic [7:0] next_holdoff_count;
	logic [1:0] next_holdoff_ref_divider;
	logic [7:0] next_rdata;

	sel_state_t state;
	sel_state_t next_state;
	logic cur;
	logic next_cur;
	logic swapped;
	logic next_swapped;
	logic failover;
	logic next_failover;

	selection_mode_t mode;
	logic sel_src;
	logic los_cur;
	logic los_other;
	logic los_primary;
	logic reval_other;

	holdoff_if hif ();

	holdoff_counter u_counter (
		.clk(MCLK),
		.reset(RESET),
		.hif(hif.cnt)
	);

	// Register file.
	always_comb
	begin
		next_ext_int = ext_int;
		next_holdover_mode_control = holdover_mode_control;
		next_revertive_enable = revertive_enable;
		next_selection_mode = selection_mode;
		next_int_sel = int_sel;
		next_holdoff_count = holdoff_count;
		next_holdoff_ref_divider = holdoff_ref_divider;
		if (REG_WR)
		begin
			case (REG_ADDR)
				`ADDR_HOLDOVER_CTRL:
				begin
					next_ext_int = REG_WDATA[`BIT_EXT_INT];
					next_holdover_mode_control =
						REG_WDATA[`BIT_HOLDOVER_CTRL];
				end
				`ADDR_MODE_CTRL:
				begin
					next_revertive_enable = REG_WDATA[`BIT_REVERTIVE_ENABLE];
					next_selection_mode =
						REG_WDATA[`BIT_MODE_HI:`BIT_MODE_LO];
					next_int_sel = REG_WDATA[`BIT_INT_SEL];
				end
				`ADDR_HOLDOFF_COUNT: next_holdoff_count = REG_WDATA;
				`ADDR_HOLDOFF_DIV:
				begin
					next_holdoff_ref_divider =
						REG_WDATA[`BIT_DIV_HI:`BIT_DIV_LO];
				end
				default: ;
			endcase
		end
		next_rdata = 8'h00;
		case (REG_ADDR)
			`ADDR_HOLDOVER_CTRL:
			begin
				next_rdata[`BIT_EXT_INT] = ext_int;
				next_rdata[`BIT_HOLDOVER_CTRL] = holdover_mode_control;
			end
			`ADDR_MODE_CTRL:
			begin
				next_rdata[`BIT_REVERTIVE_ENABLE] = revertive_enable;
				next_rdata[`BIT_MODE_HI:`BIT_MODE_LO] = selection_mode;
				next_rdata[`BIT_INT_SEL] = int_sel;
			end
			`ADDR_HOLDOFF_COUNT: next_rdata = holdoff_count;
			`ADDR_HOLDOFF_DIV:
			begin
				next_rdata[`BIT_DIV_HI:`BIT_DIV_LO] = holdoff_ref_divider;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			ext_int <= `RST_EXT_INT;
			holdover_mode_control <= `RST_HOLDOVER_CTRL;
			revertive_enable <= `RST_REVERTIVE_ENABLE;
			selection_mode <= `RST_MODE;
			int_sel <= `RST_INT_SEL;
			holdoff_count <= `RST_HOLDOFF_COUNT;
			holdoff_ref_divider <= `RST_HOLDOFF_DIV;
			rdata <= 8'h00;
		end
		else
		begin
			ext_int <= next_ext_int;
			holdover_mode_control <= next_holdover_mode_control;
			revertive_enable <= next_revertive_enable;
			selection_mode <= next_selection_mode;
			int_sel <= next_int_sel;
			holdoff_count <= next_holdoff_count;
			holdoff_ref_divider <= next_holdoff_ref_divider;
			rdata <= next_rdata;
		end
	end

	// Effective mode and status of the inputs.
	always_comb
	begin
		// With holdover control clear the field has no effect.
		if (holdover_mode_control)
			mode = selection_mode_t'(selection_mode);
		else
			mode = MODE_MANUAL;
		sel_src = ext_int ? int_sel : EXT_SEL;
		los_cur = cur ? LOS1 : LOS0;
		los_other = cur ? LOS0 : LOS1;
		los_primary = sel_src ? LOS1 : LOS0;
		reval_other = cur ? REVAL0 : REVAL1;
	end

	// Selection state machine.
	always_comb
	begin
		next_state = state;
		next_cur = cur;
		next_swapped = swapped;
		next_failover = 1'b0;
		case (mode)
			MODE_MANUAL:
			begin
				next_state = ST_TRACK;
				next_swapped = 1'b0;
				next_cur = sel_src;
			end
			MODE_SHORT_HOLDOVER:
			begin
				next_cur = sel_src ^ swapped;
				if (state == ST_TRACK && los_cur)
					next_state = ST_HOLDOFF;
				else if (state == ST_HOLDOFF && hif.expire)
				begin
					next_state = ST_TRACK;
					next_swapped = ~swapped;
					next_cur = ~cur;
					next_failover = 1'b1;
				end
				else if (state == ST_HOLDOFF && !los_cur)
					next_state = ST_TRACK;
			end
			default:
			begin
				// Automatic modes: primary preferred, loss of the selected input with the other input good forces a switch, in MODE_AUTO_HOLDOVER only once the hold-off expires.
				next_swapped = 1'b0;
				if (state == ST_HOLDOFF)
				begin
					if (hif.expire)
					begin
						next_state = ST_TRACK;
						next_cur = ~cur;
						next_failover = 1'b1;
					end
					else if (!los_cur)
						next_state = ST_TRACK;
				end
				else if (los_cur && !los_other)
				begin
					if (mode == MODE_AUTO_HOLDOVER)
						next_state = ST_HOLDOFF;
					else
					begin
						next_cur = ~cur;
						next_failover = 1'b1;
					end
				end
				// Revertive reselection only in automatic modes.
				else if (reval_other && revertive_enable)
				begin
					next_cur = los_primary ? ~sel_src : sel_src;
				end
				// Without revertive switching the selection stays put.
				else
					next_cur = cur;
			end
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RESET)
		begin
			state <= ST_TRACK;
			cur <= 1'b0;
			swapped <= 1'b0;
			failover <= 1'b0;
		end
		else
		begin
			state <= next_state;
			cur <= next_cur;
			swapped <= next_swapped;
			failover <= next_failover;
		end
	end

	assign hif.enable = (state == ST_HOLDOFF);
	assign hif.vcxo_tick = VCXO_TICK;
	assign hif.setting = holdoff_count;
	assign hif.divider = holdoff_ref_divider;

	assign REG_RDATA = rdata;
	assign REF_SEL = cur;
	assign HOLDOFF_ACTIVE = (state == ST_HOLDOFF);
	assign FAILOVER = failover;

endmodule : clock_input_selection_control

`default_nettype wire

// ===== test/clksel_properties.sv
// Purpose: Port-level properties of the clock input selection control.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module after the checker.
`timescale 1ns/1ps
`default_nettype none

module clksel_properties
(
	// Clock and reset
	input wire logic MCLK,
	input wire logic RESET,
	// Watched ports
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_RDATA,
	input wire logic LOS0,
	input wire logic LOS1,
	input wire logic REF_SEL,
	input wire logic HOLDOFF_ACTIVE,
	input wire logic FAILOVER
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RESET);

	a_fail_pulse: assert property (FAILOVER |=> !FAILOVER)
		else $error("failover pulse too long");
	a_fail_toggle: assert property (
		FAILOVER |-> REF_SEL != $past(REF_SEL))
		else $error("failover without a switch");
	a_fail_hold: assert property (
		FAILOVER && $past(HOLDOFF_ACTIVE) |-> !HOLDOFF_ACTIVE)
		else $error("hold-off still active after switch");
	a_reset_clear: assert property (disable iff (1'b0)
		RESET |=> !REF_SEL && !FAILOVER && !HOLDOFF_ACTIVE)
		else $error("outputs not cleared by reset");
	a_unmapped_zero: assert property (
		REG_ADDR[7:2] != 6'h08 |=> REG_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_mode_rsvd: assert property (REG_ADDR == 8'h21 |=>
		REG_RDATA[7:5] == 3'h0 && !REG_RDATA[1])
		else $error("reserved mode bits not zero");
	a_hold_entry: assert property (
		$rose(HOLDOFF_ACTIVE) |-> $past(LOS0 || LOS1))
		else $error("hold-off started without loss");
	a_hold_drop: assert property (
		HOLDOFF_ACTIVE && !LOS0 && !LOS1 |=> !HOLDOFF_ACTIVE)
		else $error("hold-off kept after loss cleared");
endmodule : clksel_properties

bind clock_input_selection_control clksel_properties u_clksel_properties (
	.MCLK, .RESET, .REG_ADDR, .REG_RDATA, .LOS0, .LOS1, .REF_SEL,
	.HOLDOFF_ACTIVE, .FAILOVER);

`default_nettype wire

// ===== test/clock_pair_model.sv
// Purpose: Model of the two redundant input clocks seen by the selector.
// Assumes: A fail request makes an input lose its signal.
// Notes: VCXO pulses every cycle to keep hold-off runs short.
`timescale 1ns/1ps
`default_nettype none

module clock_pair_model
(
	// Clock
	input wire logic clk,
	// Requests from the bench
	input wire logic [1:0] fail,
	// Status towards the selector
	output logic [1:0] los,
	output logic [1:0] reval,
	output logic tick
);
	logic [1:0] los_q = 2'h0;
	logic [1:0] reval_q = 2'h0;
	logic [1:0] good [2] = '{2'h0, 2'h0};

	assign los = los_q;
	assign reval = reval_q;
	assign tick = 1'b1;

	// A lost input revalidates after four clean cycles.
	always @(posedge clk)
		for (int i = 0; i < 2; i++)
		begin
			reval_q[i] <= 1'b0;
			good[i] <= fail[i] ? 2'h0 : good[i] + 2'h1;
			if (fail[i])
				los_q[i] <= 1'b1;
			else if (los_q[i] && good[i] == 2'h3)
			begin
				los_q[i] <= 1'b0;
				reval_q[i] <= 1'b1;
			end
		end
endmodule : clock_pair_model

`default_nettype wire

// ===== test/clock_input_selection_control_tb.sv
// Purpose: Self-checking bench for the clock input selection control.
// Assumes: Inputs driven at the rising edge by non-blocking assignment.
// Notes: Hold-off runs use divider 00; the runs timed to expiry use a setting of one.
`timescale 1ns/1ps
`default_nettype none
`include "clksel_map.svh"

module clock_input_selection_control_tb;
	logic MCLK = 1'b0;
	logic RESET = 1'b1;
	logic [7:0] REG_ADDR = 8'h00;
	logic [7:0] REG_WDATA = 8'h00;
	logic REG_WR = 1'b0;
	logic EXT_SEL = 1'b0;
	logic [1:0] fail = 2'h0;
	logic [1:0] los;
	logic [1:0] reval;
	logic tick;
	logic [7:0] REG_RDATA;
	logic REF_SEL;
	logic HOLDOFF_ACTIVE;
	logic FAILOVER;
	int n_fail = 0;
	int n_checks = 0;

	always #5 MCLK = ~MCLK;

	clock_pair_model u_clock_pair_model (.clk(MCLK), .fail(fail),
		.los(los), .reval(reval), .tick(tick));

	clock_input_selection_control u_clock_input_selection_control (
		.MCLK, .RESET, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RDATA,
		.EXT_SEL, .LOS0(los[0]), .LOS1(los[1]), .REVAL0(reval[0]),
		.REVAL1(reval[1]), .VCXO_TICK(tick), .REF_SEL, .HOLDOFF_ACTIVE,
		.FAILOVER);

	task stop_test;
		if (n_fail == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task do_reset;
		@(posedge MCLK);
		RESET <= 1'b1;
		fail <= 2'h0;
		repeat (3) @(posedge MCLK);
		RESET <= 1'b0;
	endtask : do_reset

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		REG_ADDR <= a;
		REG_WDATA <= d;
		REG_WR <= 1'b1;
		@(posedge MCLK);
		REG_WR <= 1'b0;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge MCLK);
		REG_ADDR <= a;
		@(posedge MCLK);
		#1 chk(REG_RDATA, e);
	endtask : rd

	task sel(input logic e);
		repeat (2) @(posedge MCLK);
		#1 chk({7'h00, REF_SEL}, {7'h00, e});
	endtask : sel

	task wait_fail(input int lim, output int n);
		n = 0;
		while (FAILOVER !== 1'b1)
		begin
			@(posedge MCLK);
			#1 n++;
			if (n > lim)
			begin
				n_fail++;
				stop_test();
			end
		end
	endtask : wait_fail

	task t_regs;
		do_reset();
		rd(`ADDR_HOLDOVER_CTRL, 8'h00);
		rd(`ADDR_MODE_CTRL, 8'h00);
		rd(`ADDR_HOLDOFF_COUNT, 8'h80);
		rd(`ADDR_HOLDOFF_DIV, 8'h80);
		rd(8'h24, 8'h00);
		wr(`ADDR_MODE_CTRL, 8'hff);
		rd(`ADDR_MODE_CTRL, 8'h1d);
	endtask : t_regs

	task t_manual;
		do_reset();
		EXT_SEL <= 1'b1;
		sel(1'b1);
		wr(`ADDR_HOLDOVER_CTRL, 8'h03);
		for (int m = 0; m < 4; m += 2)
		begin
			wr(`ADDR_MODE_CTRL, 8'(m << 2));
			sel(1'b0);
			wr(`ADDR_MODE_CTRL, 8'(m << 2 | 1));
			sel(1'b1);
		end
		wr(`ADDR_HOLDOVER_CTRL, 8'h01);
		wr(`ADDR_MODE_CTRL, 8'h04);
		fail <= 2'h1;
		sel(1'b0);
	endtask : t_manual

	task t_auto;
		int n;
		do_reset();
		wr(`ADDR_HOLDOVER_CTRL, 8'h03);
		wr(`ADDR_MODE_CTRL, 8'h04);
		fail <= 2'h1;
		wait_fail(4, n);
		sel(1'b1);
		@(posedge MCLK);
		fail <= 2'h0;
		repeat (8) @(posedge MCLK);
		sel(1'b1);
		wr(`ADDR_MODE_CTRL, 8'h14);
		fail <= 2'h1;
		@(posedge MCLK);
		fail <= 2'h0;
		// A revertive switch raises no failover pulse: wait a fixed time.
		repeat (6) @(posedge MCLK);
		sel(1'b0);
	endtask : t_auto

	task t_hold;
		int n;
		do_reset();
		wr(`ADDR_HOLDOVER_CTRL, 8'h03);
		wr(`ADDR_HOLDOFF_DIV, 8'h00);
		rd(`ADDR_HOLDOFF_DIV, 8'h00);
		wr(`ADDR_MODE_CTRL, 8'h0c);
		fail <= 2'h1;
		repeat (3) @(posedge MCLK);
		fail <= 2'h0;
		repeat (10) @(posedge MCLK);
		#1 chk({6'h00, REF_SEL, HOLDOFF_ACTIVE}, 8'h00);
		wr(`ADDR_HOLDOFF_COUNT, 8'h01);
		rd(`ADDR_HOLDOFF_COUNT, 8'h01);
		fail <= 2'h1;
		wait_fail(40000, n);
		chk({7'h00, n >= 32768}, 8'h01);
		sel(1'b1);
		// Short-term holdover: input 0 is still lost once selected again.
		wr(`ADDR_MODE_CTRL, 8'h08);
		wait_fail(40000, n);
		chk({7'h00, n >= 32768}, 8'h01);
		sel(1'b1);
	endtask : t_hold

	initial
	begin
		t_regs();
		t_manual();
		t_auto();
		t_hold();
		stop_test();
	end
endmodule : clock_input_selection_control_tb

`default_nettype wire
